// ---- asdp_port.v ----
// Purpose: audio serial data port, receive side of a stereo playback path
// Assumes: 200 MHz ref_clk, classic Wishbone register access, pins sampled through two flops
// Notes:   received words land msb-aligned in a fifo drained by the dac side
//
// Functional notes
// R1 - framing selectable among left-justified, right-justified, i2s, dsp and tdm
// R2 - tdm framing also talks to plain pcm-style serial ports
// R3 - every sample travels most significant bit first
// R4 - format bits 5:4 pick word length 16, 20, 24 or 32
// R5 - word clock and bit clock each independently master or slave
// R6 - word clock marks each frame start; receiver aligns frames to it
// R7 - generated word clock is either a short pulse or a square wave
// R8 - word clock runs at sample rate, one frame per sample
// R9 - each data bit moves on a bit clock edge
// R10 - master bit clock comes from the programmable divider register
// R11 - bit clocks per frame adjustable for word length and shared buses
// R12 - first data bit delayed by programmable count of bit clocks
// R13 - polarity bit 3 inverts the data bit clock edge in every format
// R14 - port powered down in master mode puts all pins high impedance
// R15 - generated clocks toggle only while the dac is powered
// R16 - optional setting keeps generated clocks running with dac down
// R17 - in slave mode host supplies clocks with enough bits per frame
//
// Implementation choice: the Wishbone interface to the registers.
`timescale 1ns/1ps
`include "asdp_map.vh"
module asdp_port #(
  parameter FIFO_DEPTH = 8,
  parameter FIFO_AW    = 3
) (
  // clock and reset
  input  wire        ref_clk,
  input  wire        reset,
  // wishbone slave
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [9:0]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  // bit clock pin
  input  wire        bclk_in,
  output reg         bclk_out,
  output reg         bclk_oe,
  // word clock pin
  input  wire        wclk_in,
  output reg         wclk_out,
  output reg         wclk_oe,
  // serial data pin
  input  wire        sdata_in,
  // samples toward the dac
  output wire        sample_valid,
  input  wire        sample_ready,
  output wire [31:0] sample_data,
  output wire        sample_right
);
  // word length in bits from its code
  function [8:0] wlen_bits;
    input [1:0] code;
    begin
      case (code)
        `ASDP_WLEN_16: wlen_bits = 9'h010;
        `ASDP_WLEN_20: wlen_bits = 9'h014;
        `ASDP_WLEN_24: wlen_bits = 9'h018;
        default:       wlen_bits = 9'h020;
      endcase
    end
  endfunction

  // registers
  reg  [7:0]  audio_format_control;
  reg  [7:0]  data_start_offset;
  reg  [7:0]  bit_clock_polarity_control;
  reg  [7:0]  bit_clock_divider;
  reg  [7:0]  port_control;
  reg  [7:0]  frame_length;
  reg         overflow;

  // pin synchronisers
  reg         bclk_s1, bclk_s2, bclk_s3;
  reg         wclk_s1, wclk_s2;
  reg         sdata_s1, sdata_s2;

  // clock generation and framing
  reg  [7:0]  div_cnt;
  reg         bclk_gen;
  reg  [8:0]  bitpos;
  reg         wclk_prev;
  reg  [31:0] shreg;
  reg  [31:0] hold_data;
  reg         hold_right;
  reg         hold_valid;

  wire [1:0]  mode       = audio_format_control[`ASDP_FMT_MODE_HI:`ASDP_FMT_MODE_LO];
  wire [8:0]  wl         = wlen_bits(audio_format_control[`ASDP_FMT_WLEN_HI:`ASDP_FMT_WLEN_LO]);
  wire        bclk_mst   = audio_format_control[`ASDP_FMT_BCLK_MST];
  wire        wclk_mst   = audio_format_control[`ASDP_FMT_WCLK_MST];
  wire        invert     = bit_clock_polarity_control[`ASDP_POL_INVERT];
  wire        port_on    = port_control[`ASDP_CTL_PORT_ON];
  wire        tdm        = port_control[`ASDP_CTL_TDM];
  wire        gen_run    = port_on & (port_control[`ASDP_CTL_DAC_ON] |  // [R15]
                                      port_control[`ASDP_CTL_KEEP_CLK]); // [R16]
  wire [8:0]  flen       = (frame_length == 8'h00) ? 9'h100 : {1'b0, frame_length};
  wire [8:0]  half       = {1'b0, flen[8:1]};
  wire [7:0]  div_end    = bit_clock_divider - 8'h01;

  // bus decode
  wire        wb_req     = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire [7:0]  wb_idx     = wb_adr_i[9:2];
  wire        wb_wr      = wb_ack_o & wb_we_i & wb_sel_i[0];
  wire        fifo_ready;
  wire        fifo_full  = ~fifo_ready;

  // bit clock divider; divider value 0 means 256 ref cycles per half period
  wire        gen_tick   = bclk_mst & gen_run & (div_cnt == div_end);  // [R10]
  wire        rise       = bclk_mst ? (gen_tick & ~bclk_gen) : (bclk_s2 & ~bclk_s3);
  wire        fall       = bclk_mst ? (gen_tick & bclk_gen) : (~bclk_s2 & bclk_s3);
  wire        samp       = port_on & (invert ? fall : rise);            // [R9] [R13]
  wire        launch     = port_on & (invert ? rise : fall);            // [R13]

  // frame start: i2s frames open on a falling word clock, the rest on a rising one
  wire        wclk_edge  = (mode == `ASDP_MODE_I2S) ? (wclk_prev & ~wclk_s2)
                                                    : (~wclk_prev & wclk_s2);
  wire        frame_st   = wclk_mst ? (bitpos >= flen) : wclk_edge;     // [R6]
  wire [8:0]  pos_now    = frame_st ? 9'h000 : bitpos;

  // slot placement inside the frame
  reg  [8:0]  left_start;
  reg  [8:0]  right_start;
  always @* begin
    case (mode)
      `ASDP_MODE_I2S: left_start = 9'h001;
      `ASDP_MODE_RJF: left_start = half - wl;
      default:        left_start = 9'h000;
    endcase
    left_start = left_start + {1'b0, data_start_offset};               // [R12]
    // dsp and tdm pack channels back to back, the others split the frame
    if (mode == `ASDP_MODE_DSP || tdm)                                 // [R1] [R2]
      right_start = left_start + wl;
    else
      right_start = left_start + half;
  end

  wire        in_left    = (pos_now >= left_start) & (pos_now < left_start + wl);
  wire        in_right   = (pos_now >= right_start) & (pos_now < right_start + wl);
  wire        last_left  = in_left & (pos_now == left_start + wl - 9'h001);
  wire        last_right = in_right & (pos_now == right_start + wl - 9'h001);
  wire [31:0] word_full  = {shreg[30:0], sdata_s2};
  wire [5:0]  pad        = 6'h20 - wl[5:0];

  // generated word clock level for the next sampled bit
  wire        wclk_pulse = (bitpos == 9'h000) | (bitpos >= flen);
  wire        wclk_sq    = (bitpos < half) | (bitpos >= flen);
  wire        wclk_lvl   = port_control[`ASDP_CTL_WCLK_SQ] ? wclk_sq : wclk_pulse; // [R7]

  // pin synchronisers, first stage read only by the second
  always @(posedge ref_clk) begin
    if (reset) begin
      bclk_s1  <= 1'b0;
      bclk_s2  <= 1'b0;
      bclk_s3  <= 1'b0;
      wclk_s1  <= 1'b0;
      wclk_s2  <= 1'b0;
      sdata_s1 <= 1'b0;
      sdata_s2 <= 1'b0;
    end else begin
      bclk_s1  <= bclk_in;
      bclk_s2  <= bclk_s1;
      bclk_s3  <= bclk_s2;
      wclk_s1  <= wclk_in;
      wclk_s2  <= wclk_s1;
      sdata_s1 <= sdata_in;
      sdata_s2 <= sdata_s1;
    end
  end

  // wishbone register access, answer one cycle after the request
  always @(posedge ref_clk) begin
    if (reset) begin
      wb_ack_o                   <= 1'b0;
      wb_dat_o                   <= 32'h00000000;
      audio_format_control       <= `ASDP_RST_FORMAT;
      data_start_offset          <= `ASDP_RST_OFFSET;
      bit_clock_polarity_control <= `ASDP_RST_POLARITY;
      bit_clock_divider          <= `ASDP_RST_BCLK_DIV;
      port_control               <= `ASDP_RST_CONTROL;
      frame_length               <= `ASDP_RST_FRAME_LEN;
    end else begin
      wb_ack_o <= wb_req;
      if (wb_req) begin
        case (wb_idx)
          `ASDP_IDX_FORMAT:    wb_dat_o <= {24'h000000, audio_format_control};
          `ASDP_IDX_OFFSET:    wb_dat_o <= {24'h000000, data_start_offset};
          `ASDP_IDX_POLARITY:  wb_dat_o <= {24'h000000, bit_clock_polarity_control};
          `ASDP_IDX_BCLK_DIV:  wb_dat_o <= {24'h000000, bit_clock_divider};
          `ASDP_IDX_CONTROL:   wb_dat_o <= {24'h000000, port_control};
          `ASDP_IDX_FRAME_LEN: wb_dat_o <= {24'h000000, frame_length};
          `ASDP_IDX_STATUS:    wb_dat_o <= {29'h00000000, fifo_full, sample_valid, overflow};
          default:             wb_dat_o <= 32'h00000000;
        endcase
      end
      if (wb_wr) begin
        case (wb_idx)
          `ASDP_IDX_FORMAT:    audio_format_control       <= wb_dat_i[7:0]; // [R4] [R5]
          `ASDP_IDX_OFFSET:    data_start_offset          <= wb_dat_i[7:0]; // [R12]
          `ASDP_IDX_POLARITY:  bit_clock_polarity_control <= wb_dat_i[7:0]; // [R13]
          `ASDP_IDX_BCLK_DIV:  bit_clock_divider          <= wb_dat_i[7:0]; // [R10]
          `ASDP_IDX_CONTROL:   port_control               <= wb_dat_i[7:0];
          `ASDP_IDX_FRAME_LEN: frame_length               <= wb_dat_i[7:0]; // [R11]
          default: ;
        endcase
      end
    end
  end

  // bit clock generator, idles low when stopped
  always @(posedge ref_clk) begin
    if (reset) begin
      div_cnt  <= 8'h00;
      bclk_gen <= 1'b0;
    end else if (!(bclk_mst & gen_run)) begin                          // [R15]
      div_cnt  <= 8'h00;
      bclk_gen <= 1'b0;
    end else if (gen_tick) begin
      div_cnt  <= 8'h00;
      bclk_gen <= ~bclk_gen;
    end else begin
      div_cnt  <= div_cnt + 8'h01;
    end
  end

  // pin drivers; all enables drop with the port powered down
  always @(posedge ref_clk) begin
    if (reset) begin
      bclk_out <= 1'b0;
      bclk_oe  <= 1'b0;
      wclk_out <= 1'b0;
      wclk_oe  <= 1'b0;
    end else begin
      bclk_oe  <= port_on & bclk_mst;                                   // [R5] [R14]
      wclk_oe  <= port_on & wclk_mst;                                   // [R5] [R14]
      bclk_out <= bclk_gen;
      if (!(wclk_mst & gen_run))
        wclk_out <= 1'b0;                                               // [R15]
      else if (launch)
        wclk_out <= (mode == `ASDP_MODE_I2S) ? ~wclk_lvl : wclk_lvl;    // [R8]
    end
  end

  // serial receiver: frame position, msb-first shift and word hand-off
  always @(posedge ref_clk) begin
    if (reset) begin
      bitpos     <= 9'h000;
      wclk_prev  <= 1'b0;
      shreg      <= 32'h00000000;
      hold_data  <= 32'h00000000;
      hold_right <= 1'b0;
      hold_valid <= 1'b0;
      overflow   <= 1'b0;
    end else begin
      if (hold_valid & fifo_ready)
        hold_valid <= 1'b0;
      // write one to clear; a new overflow in the same cycle wins
      if (wb_wr && wb_idx == `ASDP_IDX_STATUS && wb_dat_i[`ASDP_STS_OVERFLOW])
        overflow <= 1'b0;
      if (samp) begin
        wclk_prev <= wclk_s2;
        // slave frames follow the word clock; a frame with no edge runs the count on until it holds at 511
        bitpos    <= (pos_now == 9'h1ff) ? pos_now : pos_now + 9'h001; // [R6] [R8]
        if (in_left | in_right)
          shreg <= word_full;                                           // [R3] [R9]
        if (last_left | last_right) begin
          // one word of room; the dac side stalling here shows as overflow
          if (hold_valid & ~fifo_ready) begin
            overflow <= 1'b1;
          end else begin
            hold_data  <= word_full << pad;                             // [R3] [R4]
            hold_right <= last_right;
            hold_valid <= 1'b1;
          end
        end
      end
    end
  end

  asdp_fifo #(
    .WIDTH (33),
    .DEPTH (FIFO_DEPTH),
    .AW    (FIFO_AW)
  ) u_fifo (
    .ref_clk   (ref_clk),
    .reset     (reset),
    .in_valid  (hold_valid),
    .in_ready  (fifo_ready),
    .in_data   ({hold_right, hold_data}),
    .out_valid (sample_valid),
    .out_ready (sample_ready),
    .out_data  ({sample_right, sample_data})
  );
endmodule

// ---- asdp_map.vh ----
// Purpose: register map, field positions and reset values of the audio serial data port
// Assumes: 32-bit classic Wishbone, one register per aligned word, byte address = 4 * index
// Notes:   narrow registers sit in the low byte, upper bits read as zero
`ifndef ASDP_MAP_VH
`define ASDP_MAP_VH

// register indices
`define ASDP_IDX_FORMAT      8'h1b
`define ASDP_IDX_OFFSET      8'h1c
`define ASDP_IDX_POLARITY    8'h1d
`define ASDP_IDX_BCLK_DIV    8'h1e
`define ASDP_IDX_CONTROL     8'h20
`define ASDP_IDX_FRAME_LEN   8'h21
`define ASDP_IDX_STATUS      8'h22

// audio_format_control fields
`define ASDP_FMT_MODE_HI     7
`define ASDP_FMT_MODE_LO     6
`define ASDP_FMT_WLEN_HI     5
`define ASDP_FMT_WLEN_LO     4
`define ASDP_FMT_BCLK_MST    3
`define ASDP_FMT_WCLK_MST    2

// framing modes
`define ASDP_MODE_I2S        2'h0
`define ASDP_MODE_DSP        2'h1
`define ASDP_MODE_RJF        2'h2
`define ASDP_MODE_LJF        2'h3

// word length codes
`define ASDP_WLEN_16         2'h0
`define ASDP_WLEN_20         2'h1
`define ASDP_WLEN_24         2'h2
`define ASDP_WLEN_32         2'h3

// bit_clock_polarity_control field
`define ASDP_POL_INVERT      3

// control register fields
`define ASDP_CTL_PORT_ON     0
`define ASDP_CTL_DAC_ON      1
`define ASDP_CTL_KEEP_CLK    2
`define ASDP_CTL_WCLK_SQ     3
`define ASDP_CTL_TDM         4

// status register fields
`define ASDP_STS_OVERFLOW    0
`define ASDP_STS_OUT_VALID   1
`define ASDP_STS_FULL        2

// reset values
`define ASDP_RST_FORMAT      8'h00
`define ASDP_RST_OFFSET      8'h00
`define ASDP_RST_POLARITY    8'h00
`define ASDP_RST_BCLK_DIV    8'h01
`define ASDP_RST_CONTROL     8'h00
`define ASDP_RST_FRAME_LEN   8'h40

`endif

// ---- asdp_fifo.v ----
// Purpose: sample fifo between serial receiver and dac side
// Assumes: single clock, synchronous active-high reset
// Notes:   registered output stage, so capacity is DEPTH plus one word
`timescale 1ns/1ps
module asdp_fifo #(
  parameter WIDTH = 33,
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  // clock and reset
  input  wire             ref_clk,
  input  wire             reset,
  // fill side
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  // drain side
  output reg              out_valid,
  input  wire             out_ready,
  output reg  [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr;
  reg [AW-1:0]    rd_ptr;
  reg [AW:0]      count;
  wire            push;
  wire            pop;

  assign in_ready = (count < DEPTH[AW:0]);
  assign push     = in_valid & in_ready;
  assign pop      = (count != {(AW+1){1'b0}}) & (~out_valid | out_ready);

  always @(posedge ref_clk) begin
    if (reset) begin
      wr_ptr    <= {AW{1'b0}};
      rd_ptr    <= {AW{1'b0}};
      count     <= {(AW+1){1'b0}};
      out_valid <= 1'b0;
      out_data  <= {WIDTH{1'b0}};
    end else begin
      if (push) begin
        mem[wr_ptr] <= in_data;
        wr_ptr      <= (wr_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr + 1'b1;
      end
      if (pop) begin
        out_data  <= mem[rd_ptr];
        out_valid <= 1'b1;
        rd_ptr    <= (rd_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr + 1'b1;
      end else if (out_ready) begin
        out_valid <= 1'b0;
      end
      count <= count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end
  end
endmodule

// ---- asdp_port_chk.sv ----
// Purpose: assertions on the audio serial port bus and pins
// Assumes: bus writes shadowed here match the register state
// Notes:   bound to every asdp_port
`timescale 1ns/1ps
`include "asdp_map.vh"
module asdp_port_chk #(
  parameter FIFO_DEPTH = 8,
  parameter FIFO_AW    = 3
) (
  // clock and reset
  input wire        ref_clk,
  input wire        reset,
  // bus
  input wire        wb_cyc_i,
  input wire        wb_stb_i,
  input wire        wb_we_i,
  input wire [9:0]  wb_adr_i,
  input wire [3:0]  wb_sel_i,
  input wire [31:0] wb_dat_i,
  input wire [31:0] wb_dat_o,
  input wire        wb_ack_o,
  // pins
  input wire        bclk_in,
  input wire        bclk_out,
  input wire        bclk_oe,
  input wire        wclk_in,
  input wire        wclk_out,
  input wire        wclk_oe,
  input wire        sdata_in,
  // dac side
  input wire        sample_valid,
  input wire        sample_ready,
  input wire [31:0] sample_data,
  input wire        sample_right
);
  logic [7:0] fmt;
  logic [7:0] ctl;
  logic [7:0] div;
  logic [8:0] cnt;
  logic       pb;
  logic       seen;
  wire        wr_ok = wb_ack_o & wb_cyc_i & wb_stb_i & wb_we_i & wb_sel_i[0];
  wire [7:0]  idx   = wb_adr_i[9:2];
  wire        stop  = ~ctl[1] & ~ctl[2];
  wire        b_own = ctl[0] & fmt[3];
  wire        w_own = ctl[0] & fmt[2];
  wire [8:0]  half  = (div == 8'h00) ? 9'h100 : {1'b0, div};
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  // shadow only what steers the pins
  always @(posedge ref_clk) begin
    if (reset) begin
      fmt <= `ASDP_RST_FORMAT;
      ctl <= `ASDP_RST_CONTROL;
      div <= `ASDP_RST_BCLK_DIV;
    end else if (wr_ok) begin
      if (idx == `ASDP_IDX_FORMAT) fmt <= wb_dat_i[7:0];
      if (idx == `ASDP_IDX_CONTROL) ctl <= wb_dat_i[7:0];
      if (idx == `ASDP_IDX_BCLK_DIV) div <= wb_dat_i[7:0];
    end
  end
  // cycles since the last bit clock change; first toggle after a start is not trusted
  always @(posedge ref_clk) begin
    pb <= bclk_out;
    cnt <= reset ? 9'h000 : (bclk_out != pb) ? 9'h001 : (cnt == 9'h1ff) ? cnt : cnt + 9'h001;
    seen <= ~reset & bclk_oe & ~stop & (seen | (bclk_out != pb));
  end
  a_ack_next:
    assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus request not answered next cycle");
  a_ack_single:
    assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_read_zero:
    assert property (wb_ack_o && !wb_we_i |-> wb_dat_o[31:8] == 24'h000000)
    else $error("read data upper bits set");
  a_bclk_drive:
    assert property (!$past(reset) |-> bclk_oe == $past(b_own))
    else $error("bit clock enable wrong");
  a_wclk_drive:
    assert property (!$past(reset) |-> wclk_oe == $past(w_own))
    else $error("word clock enable wrong");
  a_clock_stop:
    assert property (stop [*8] |-> !bclk_out && !wclk_out)
    else $error("clocks run with dac off");
  a_bclk_half:
    assert property ($changed(bclk_out) && seen && bclk_oe && !stop |-> cnt == half)
    else $error("bit clock half period wrong");
  a_keep_running:
    assert property (bclk_oe && ctl[2] && !ctl[1] && seen |-> cnt <= half)
    else $error("bit clock stalled while kept");
  a_sample_hold:
    assert property (sample_valid && !sample_ready |=> sample_valid && $stable(sample_data)
                     && $stable(sample_right))
    else $error("sample changed before taken");
  cover property (sample_valid && sample_ready);
  cover property (bclk_oe && wclk_oe && wclk_out);
  cover property (bclk_oe && !wclk_oe);
endmodule
bind asdp_port asdp_port_chk #(.FIFO_DEPTH(FIFO_DEPTH), .FIFO_AW(FIFO_AW)) chk_i (
  .ref_clk(ref_clk), .reset(reset), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .bclk_in(bclk_in), .bclk_out(bclk_out),
  .bclk_oe(bclk_oe), .wclk_in(wclk_in), .wclk_out(wclk_out), .wclk_oe(wclk_oe),
  .sdata_in(sdata_in), .sample_valid(sample_valid), .sample_ready(sample_ready),
  .sample_data(sample_data), .sample_right(sample_right)
);

// ---- asdp_host.sv ----
// Purpose: host model driving both clocks and data into the port
// Assumes: port clocks are slaves; eight ref cycles per bit clock half
// Notes:   bit clock stands still and data is scrambled between frames
`timescale 1ns/1ps
module asdp_host (
  // timing
  input  wire  ref_clk,
  // pins
  output logic bclk,
  output logic wclk,
  output logic sdata
);
  localparam int H  = 8;
  localparam int FL = 64; // room for two 32-bit words
  initial begin
    bclk = 1'b0;
    wclk = 1'b0;
    sdata = 1'b0;
  end
  // one frame, led by one bit at the idle word clock level so its edge is seen
  task automatic send(input logic [1:0] md, input int wl, input int off, input logic inv,
                      input logic [31:0] l, input logic [31:0] r);
    int ls;
    int rs;
    ls = ((md == 2'h0) ? 1 : (md == 2'h2) ? FL / 2 - wl : 0) + off;
    rs = (md == 2'h1) ? ls + wl : ls + FL / 2;
    for (int p = -1; p < FL; p++) begin
      @(posedge ref_clk);
      bclk <= inv; // launch edge
      wclk <= (md == 2'h0) ? (p < 0 || p >= FL / 2) : // frame start
              (md == 2'h1) ? (p == 0) : (p >= 0 && p < FL / 2);
      sdata <= (p >= ls && p < ls + wl) ? l[31 - (p - ls)] : // msb first
               (p >= rs && p < rs + wl) ? r[31 - (p - rs)] : p[0];
      repeat (H) @(posedge ref_clk);
      bclk <= !inv;
      repeat (H - 1) @(posedge ref_clk);
    end
    @(posedge ref_clk);
    sdata <= !sdata;
  endtask
endmodule

// ---- asdp_port_test.sv ----
// Purpose: self-checking bench for the audio serial port
// Assumes: host model drives the pins while the port is slave
// Notes:   fifo capacity is judged to within one word (ten or eleven pass), ten of twelve stalled words kept
`timescale 1ns/1ps
`include "asdp_map.vh"
module asdp_port_test;
  logic        ref_clk = 1'b0;
  logic        reset = 1'b1;
  logic        wb_cyc_i = 1'b0;
  logic        wb_stb_i = 1'b0;
  logic        wb_we_i = 1'b0;
  logic [9:0]  wb_adr_i = 10'h000;
  logic [3:0]  wb_sel_i = 4'hf;
  logic [31:0] wb_dat_i = 32'h0000_0000;
  logic        sample_ready = 1'b1;
  logic [31:0] wb_dat_o;
  logic [31:0] sample_data;
  logic        wb_ack_o, bclk_out, bclk_oe, wclk_out, wclk_oe, sample_valid, sample_right;
  logic        h_bclk, h_wclk, h_sdata;
  wire         bclk_in = bclk_oe ? bclk_out : h_bclk;
  wire         wclk_in = wclk_oe ? wclk_out : h_wclk;
  int          fail_count = 0;
  int          n_checks = 0;
  logic [32:0] got[$];
  localparam logic [31:0] lw = 32'h9a5c_3e71;
  localparam logic [31:0] rw = 32'h61c3_a58e;
  asdp_port #(.FIFO_DEPTH(8), .FIFO_AW(3)) uut (
    .ref_clk(ref_clk), .reset(reset), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .bclk_in(bclk_in), .bclk_out(bclk_out),
    .bclk_oe(bclk_oe), .wclk_in(wclk_in), .wclk_out(wclk_out), .wclk_oe(wclk_oe),
    .sdata_in(h_sdata), .sample_valid(sample_valid), .sample_ready(sample_ready),
    .sample_data(sample_data), .sample_right(sample_right)
  );
  asdp_host host (.ref_clk(ref_clk), .bclk(h_bclk), .wclk(h_wclk), .sdata(h_sdata));
  initial forever #2.5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    if (sample_valid === 1'b1 && sample_ready === 1'b1) got.push_back({sample_right, sample_data});
  end
  task chk(input logic ok, input string m);
    n_checks++;
    if (ok !== 1'b1) begin
      fail_count++;
      $display("unexpected at %0t: %s", $time, m);
    end
  endtask
  task wb(input logic we, input logic [7:0] idx, input logic [7:0] d, output logic [7:0] q);
    int n;
    n = 0;
    @(posedge ref_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= {idx, 2'b00};
    wb_dat_i <= {24'h000000, d};
    do begin
      @(posedge ref_clk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 40);
    q = wb_dat_o[7:0];
    chk(n < 40, "no bus answer");
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task wr(input logic [7:0] idx, input logic [7:0] d);
    logic [7:0] q;
    wb(1'b1, idx, d, q);
  endtask
  task rd(input logic [7:0] idx, input logic [7:0] e);
    logic [7:0] q;
    wb(1'b0, idx, 8'h00, q);
    chk(q === e, "register read");
  endtask
  task wait_got(input int n);
    int t;
    t = 0;
    while (got.size() < n && t < 3000) begin
      @(posedge ref_clk);
      t++;
    end
  endtask
  task regs;
    rd(`ASDP_IDX_FORMAT, `ASDP_RST_FORMAT);
    rd(`ASDP_IDX_OFFSET, `ASDP_RST_OFFSET);
    rd(`ASDP_IDX_POLARITY, `ASDP_RST_POLARITY);
    rd(`ASDP_IDX_BCLK_DIV, `ASDP_RST_BCLK_DIV);
    wr(8'h10, 8'hff);
    rd(8'h10, 8'h00);
    for (logic [7:0] i = `ASDP_IDX_FORMAT; i <= `ASDP_IDX_BCLK_DIV; i++) begin
      wr(i, 8'ha3);
      rd(i, 8'ha3);
    end
  endtask
  task rx(input logic [1:0] md, input logic [1:0] wc, input logic [7:0] off, input logic inv,
          input logic tdm);
    int wl;
    logic [31:0] m;
    wl = (wc == 2'h3) ? 32 : 16 + 4 * wc;
    m = 32'hffff_ffff << (32 - wl);
    wr(`ASDP_IDX_FORMAT, {md, wc, 4'h0});
    wr(`ASDP_IDX_OFFSET, off);
    wr(`ASDP_IDX_POLARITY, {4'h0, inv, 3'h0});
    wr(`ASDP_IDX_CONTROL, {3'h0, tdm, 4'h3});
    got.delete();
    host.send(md, wl, off, inv, lw, rw);
    wait_got(2);
    chk(got.size() == 2 && got[0] === {1'b0, lw & m} && got[1] === {1'b1, rw & m}, "words");
  endtask
  task fifo_fill;
    logic [7:0] q;
    rx(2'h0, 2'h0, 8'h00, 1'b0, 1'b0);
    // dac side stalls: twelve more words, ten fit (out stage, eight deep, hold), two drop
    sample_ready <= 1'b0;
    for (int i = 1; i < 7; i++) host.send(2'h0, 16, 0, 1'b0, lw + (i << 16), rw + (i << 16));
    wb(1'b0, `ASDP_IDX_STATUS, 8'h00, q);
    chk(q[2:0] === 3'h7, "fifo not full with overflow");
    wr(`ASDP_IDX_STATUS, 8'h01);
    wb(1'b0, `ASDP_IDX_STATUS, 8'h00, q);
    chk(q[0] === 1'b0, "overflow not cleared");
    sample_ready <= 1'b1;
    wait_got(12);
    chk(got.size() == 12, "stored word count");
    for (int i = 0; i < 12; i++) begin
      chk(got[i] === {i[0], ((i[0] ? rw : lw) + ((i / 2) << 16)) & 32'hffff_0000}, "order");
    end
  endtask
  // master clocks: divider 2, eight bit clocks a frame, so 320 cycles hold ten frames
  task mstep(input logic [7:0] f, input logic [7:0] c, input int h, input int t,
             input logic [1:0] oe);
    int hi;
    int tg;
    logic pb;
    wr(`ASDP_IDX_FORMAT, f);
    wr(`ASDP_IDX_CONTROL, c);
    repeat (100) @(posedge ref_clk);
    hi = 0;
    tg = 0;
    pb = bclk_out;
    repeat (320) begin
      @(posedge ref_clk);
      hi += (wclk_out === 1'b1);
      tg += (bclk_out !== pb);
      pb = bclk_out;
    end
    chk({bclk_oe, wclk_oe} === oe && (h < 0 || hi == h) && tg == t, "master clocks");
  endtask
  task print_verdict;
    $display("checks %0d, mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    #400000;
    fail_count++;
    print_verdict();
  end
  initial begin
    repeat (12) @(posedge ref_clk);
    reset <= 1'b0;
    regs();
    rx(2'h0, 2'h0, 8'h00, 1'b0, 1'b0);
    rx(2'h3, 2'h1, 8'h00, 1'b1, 1'b0);
    rx(2'h2, 2'h3, 8'h00, 1'b0, 1'b0);
    rx(2'h1, 2'h2, 8'h01, 1'b0, 1'b0);
    rx(2'h1, 2'h0, 8'h03, 1'b1, 1'b1);
    fifo_fill();
    wr(`ASDP_IDX_BCLK_DIV, 8'h02);
    wr(`ASDP_IDX_FRAME_LEN, 8'h08);
    mstep(8'hcc, 8'h03, 40, 160, 2'h3);
    mstep(8'hcc, 8'h0b, 160, 160, 2'h3);
    mstep(8'hcc, 8'h01, 0, 0, 2'h3);
    mstep(8'hcc, 8'h05, 40, 160, 2'h3);
    mstep(8'h08, 8'h03, -1, 160, 2'h2);
    mstep(8'hcc, 8'h00, 0, 0, 2'h0);
    print_verdict();
  end
endmodule
